// *** rtl/gdfm_defines.svh ***
// Constants of the gate driver fault manager: timing, pin slots, levels.
// Assumes a single 25 MHz system clock and asynchronous pin inputs.
`ifndef GDFM_DEFINES_SVH
`define GDFM_DEFINES_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define GDFM_CLK_PERIOD_NS 40
`define GDFM_QUIET_NS 30000
`define GDFM_CONFIRM_NS 9000
`define GDFM_QUIET_CYC ((`GDFM_QUIET_NS + `GDFM_CLK_PERIOD_NS - 1) / `GDFM_CLK_PERIOD_NS)
`define GDFM_CONFIRM_CYC ((`GDFM_CONFIRM_NS + `GDFM_CLK_PERIOD_NS - 1) / `GDFM_CLK_PERIOD_NS)

// ****************************************************************
// Synchroniser slots and levels
// ****************************************************************
`define GDFM_SYNC_W 6
`define GDFM_SLOT_CMD_UP 0
`define GDFM_SLOT_CMD_LO 1
`define GDFM_SLOT_EXT_UP 2
`define GDFM_SLOT_EXT_LO 3
`define GDFM_SLOT_HALT 4
`define GDFM_SLOT_MODE 5
`define GDFM_SYNC_RST 6'h3f
`define GDFM_LEVEL_HIGH 1'b1
`define GDFM_LEVEL_LOW 1'b0
`define GDFM_CH_UP 0
`define GDFM_CH_LO 1

`endif

// *** rtl/gdfm_pkg.sv ***
// Types shared by the gate driver fault manager files.
// Assumes nothing beyond a SystemVerilog compiler.
package gdfm_pkg;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_FAULT,
    ST_RELEASE
  } fm_state_type;

endpackage

// *** rtl/pin_sync.sv ***
// Two-flop synchroniser for a bundle of pin levels.
// Assumes a synchronous active-high reset and a reset level per bit.
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = pin_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;

endmodule // pin_sync

// *** rtl/hold_timer.sv ***
// Counts how long a condition has held without a break.
// Assumes the caller drops run_i to restart the measurement.
`timescale 1ns/1ns
module hold_timer #(
  parameter int unsigned COUNT = 16
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic run_i,
  output logic done_o
);

  localparam int CW = $clog2(COUNT + 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic done_r;
  logic done_nxt;

  // Done rises only after COUNT+1 held edges, so the time is strictly
  // longer than the figure it stands for.
  always_comb begin
    cnt_nxt = '0;
    done_nxt = 1'b0;
    if (run_i) begin
      if (cnt_r == CW'(COUNT)) begin
        cnt_nxt = cnt_r;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_o = done_r;

endmodule // hold_timer

// *** rtl/gate_driver_fault_manager.sv ***
// Fault manager of a dual-channel gate driver core.
// Assumes pins arrive as levels and the halt line is resolved outside.
`timescale 1ns/1ns
`include "gdfm_defines.svh"
module gate_driver_fault_manager #(
  parameter int unsigned QUIET_CYC = `GDFM_QUIET_CYC,
  parameter int unsigned CONFIRM_CYC = `GDFM_CONFIRM_CYC
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic fault_mode_i,
  input wire logic primary_fault_in_n_i,
  input wire logic upper_cmd_i,
  input wire logic lower_cmd_i,
  input wire logic upper_ext_fault_n_i,
  input wire logic lower_ext_fault_n_i,
  output logic fault_report_n_o,
  output logic fault_report_n_oe_o,
  output logic upper_gate_on_o,
  output logic upper_gate_off_o,
  output logic upper_gate_slow_off_o,
  output logic lower_gate_on_o,
  output logic lower_gate_off_o,
  output logic lower_gate_slow_off_o
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  logic [`GDFM_SYNC_W-1:0] pins;
  logic [`GDFM_SYNC_W-1:0] pins_s;

  assign pins[`GDFM_SLOT_CMD_UP] = upper_cmd_i;
  assign pins[`GDFM_SLOT_CMD_LO] = lower_cmd_i;
  assign pins[`GDFM_SLOT_EXT_UP] = upper_ext_fault_n_i;
  assign pins[`GDFM_SLOT_EXT_LO] = lower_ext_fault_n_i;
  assign pins[`GDFM_SLOT_HALT] = primary_fault_in_n_i;
  assign pins[`GDFM_SLOT_MODE] = fault_mode_i;

  // Reset value keeps fault inputs released and commands off.
  pin_sync #(
    .WIDTH(`GDFM_SYNC_W),
    .RST_VAL(`GDFM_SYNC_RST & ~((`GDFM_SYNC_W)'(1) << `GDFM_SLOT_CMD_UP)
      & ~((`GDFM_SYNC_W)'(1) << `GDFM_SLOT_CMD_LO))
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .pin_i(pins),
    .sync_o(pins_s)
  );

  logic [1:0] cmd_s;
  logic [1:0] ext_s;
  logic halt_low_s;
  logic seq_mode_s;

  assign cmd_s[`GDFM_CH_UP] = pins_s[`GDFM_SLOT_CMD_UP];
  assign cmd_s[`GDFM_CH_LO] = pins_s[`GDFM_SLOT_CMD_LO];
  assign ext_s[`GDFM_CH_UP] = ~pins_s[`GDFM_SLOT_EXT_UP];
  assign ext_s[`GDFM_CH_LO] = ~pins_s[`GDFM_SLOT_EXT_LO];
  assign halt_low_s = ~pins_s[`GDFM_SLOT_HALT];
  assign seq_mode_s = pins_s[`GDFM_SLOT_MODE];

  // ****************************************************************
  // Reset-sequence timers
  // ****************************************************************
  gdfm_pkg::fm_state_type state_r;
  gdfm_pkg::fm_state_type state_nxt;
  logic quiet_done;
  logic confirm_done;
  logic quiet_run;
  logic confirm_run;

  // A primary-side fault is timed from its entry, not from its removal:
  // the halt line stays low from our own report, and waiting for it to
  // rise would deadlock every driver sharing it.
  assign quiet_run = (state_r == gdfm_pkg::ST_FAULT) && (ext_s == 2'b00);
  assign confirm_run = (state_r == gdfm_pkg::ST_FAULT) && (cmd_s == 2'b00);

  hold_timer #(
    .COUNT(QUIET_CYC)
  ) u_quiet (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .run_i(quiet_run),
    .done_o(quiet_done)
  );

  hold_timer #(
    .COUNT(CONFIRM_CYC)
  ) u_confirm (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .run_i(confirm_run),
    .done_o(confirm_done)
  );

  // ****************************************************************
  // Fault state
  // ****************************************************************
  logic [1:0] aff_r;
  logic [1:0] aff_nxt;
  logic report_r;
  logic report_nxt;

  always_comb begin
    state_nxt = state_r;
    aff_nxt = aff_r;
    case (state_r)
      gdfm_pkg::ST_RUN: begin
        if (halt_low_s || (ext_s != 2'b00)) begin
          state_nxt = gdfm_pkg::ST_FAULT;
          aff_nxt = ext_s;
        end
      end
      gdfm_pkg::ST_FAULT: begin
        aff_nxt = aff_r | ext_s;
        if (quiet_done && confirm_done && (ext_s == 2'b00)) begin
          state_nxt = gdfm_pkg::ST_RELEASE;
        end
      end
      gdfm_pkg::ST_RELEASE: begin
        if (ext_s != 2'b00) begin
          state_nxt = gdfm_pkg::ST_FAULT;
          aff_nxt = aff_r | ext_s;
        end else if (!halt_low_s) begin
          state_nxt = gdfm_pkg::ST_RUN;
          aff_nxt = 2'b00;
        end
      end
      default: begin
        state_nxt = gdfm_pkg::ST_FAULT;
      end
    endcase
    report_nxt = (state_nxt == gdfm_pkg::ST_FAULT);
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_r <= gdfm_pkg::ST_RUN;
      aff_r <= 2'b00;
      report_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      aff_r <= aff_nxt;
      report_r <= report_nxt;
    end
  end

  // ****************************************************************
  // Channel output stages
  // ****************************************************************
  logic [1:0] on_r;
  logic [1:0] on_nxt;
  logic [1:0] off_r;
  logic [1:0] off_nxt;
  logic [1:0] slow_r;
  logic [1:0] slow_nxt;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      always_comb begin
        if (state_nxt == gdfm_pkg::ST_RUN) begin
          on_nxt[ch] = cmd_s[ch];
        end else begin
          // A locked channel may only stay on, never turn on again.
          on_nxt[ch] = on_r[ch] && cmd_s[ch] && seq_mode_s
            && !aff_nxt[ch];
        end
        slow_nxt[ch] = !on_nxt[ch] && aff_nxt[ch]
          && (state_nxt != gdfm_pkg::ST_RUN);
        off_nxt[ch] = !on_nxt[ch] && !slow_nxt[ch];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      on_r <= 2'b00;
      off_r <= 2'b11;
      slow_r <= 2'b00;
    end else begin
      on_r <= on_nxt;
      off_r <= off_nxt;
      slow_r <= slow_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // The open-drain report only ever drives low, so the data bit is
  // constant low and the enable carries the fault.
  assign fault_report_n_o = `GDFM_LEVEL_LOW;
  assign fault_report_n_oe_o = report_r;
  assign upper_gate_on_o = on_r[`GDFM_CH_UP];
  assign upper_gate_off_o = off_r[`GDFM_CH_UP];
  assign upper_gate_slow_off_o = slow_r[`GDFM_CH_UP];
  assign lower_gate_on_o = on_r[`GDFM_CH_LO];
  assign lower_gate_off_o = off_r[`GDFM_CH_LO];
  assign lower_gate_slow_off_o = slow_r[`GDFM_CH_LO];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_halt_forces_fault: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state_r == gdfm_pkg::ST_RUN && halt_low_s)
      |=> (state_r == gdfm_pkg::ST_FAULT && fault_report_n_oe_o))
    else $error("Halt line low did not enter the fault state.");

  a_immediate_all_off: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state_r == gdfm_pkg::ST_RUN && halt_low_s && !seq_mode_s)
      |=> (!upper_gate_on_o && !lower_gate_on_o))
    else $error("Immediate mode left a channel on after a fault.");

  a_no_new_turnon: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state_r != gdfm_pkg::ST_RUN && !upper_gate_on_o
      && state_nxt != gdfm_pkg::ST_RUN) |=> !upper_gate_on_o)
    else $error("A locked channel turned on.");

  a_seq_hold_on: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (seq_mode_s && lower_gate_on_o && cmd_s[`GDFM_CH_LO]
      && ext_s == 2'b00 && !aff_r[`GDFM_CH_LO]) |=> lower_gate_on_o)
    else $error("Sequenced mode dropped a commanded channel early.");

  a_affected_off: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state_r == gdfm_pkg::ST_RUN && ext_s[`GDFM_CH_UP])
      |=> (!upper_gate_on_o && upper_gate_slow_off_o))
    else $error("Affected channel not slowly switched off.");

  a_report_held: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state_r == gdfm_pkg::ST_FAULT) |-> (fault_report_n_oe_o
      && !(upper_gate_on_o && aff_r[`GDFM_CH_UP])
      && !(lower_gate_on_o && aff_r[`GDFM_CH_LO])))
    else $error("Fault not reported or outputs not locked.");

  a_release_seq: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state_r == gdfm_pkg::ST_FAULT && quiet_done && confirm_done
      && ext_s == 2'b00) |=> !fault_report_n_oe_o)
    else $error("Fault output not released after reset sequence.");

  a_normal_paths: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state_r == gdfm_pkg::ST_RUN) |-> (!lower_gate_slow_off_o
      && (lower_gate_on_o ^ lower_gate_off_o)))
    else $error("Normal operation used a wrong output path.");

  a_primary_std_off: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state_r == gdfm_pkg::ST_RUN && halt_low_s && ext_s == 2'b00)
      |=> (!upper_gate_slow_off_o && !lower_gate_slow_off_o))
    else $error("Primary fault used the slow-off path.");

  a_locked_off: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state_r == gdfm_pkg::ST_FAULT && !seq_mode_s)
      |=> (!upper_gate_on_o && !lower_gate_on_o))
    else $error("Immediate mode let a channel stay on in fault.");

  a_ext_reports: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state_r == gdfm_pkg::ST_RUN && ext_s != 2'b00)
      |=> (state_r == gdfm_pkg::ST_FAULT && fault_report_n_oe_o))
    else $error("Secondary fault was not reported.");

  a_release_to_run: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state_r == gdfm_pkg::ST_RELEASE && ext_s == 2'b00 && !halt_low_s)
      |=> (state_r == gdfm_pkg::ST_RUN && !fault_report_n_oe_o))
    else $error("Released driver did not return to operation.");

  a_slow_needs_aff: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    lower_gate_slow_off_o |-> (aff_r[`GDFM_CH_LO]
      && state_r != gdfm_pkg::ST_RUN))
    else $error("Slow-off used without a secondary fault.");

  a_unaffected_std: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state_r == gdfm_pkg::ST_RUN && ext_s == 2'b01 && !seq_mode_s)
      |=> (lower_gate_off_o && !lower_gate_slow_off_o))
    else $error("Unaffected channel not switched off normally.");

  a_lower_affected: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state_r == gdfm_pkg::ST_RUN && ext_s[`GDFM_CH_LO])
      |=> (!lower_gate_on_o && lower_gate_slow_off_o))
    else $error("Lower channel not slowly switched off.");

  a_lower_stays_off: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state_r == gdfm_pkg::ST_FAULT && !lower_gate_on_o)
      |=> !lower_gate_on_o)
    else $error("A locked lower channel turned on.");

  a_seq_cmd_off: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state_r == gdfm_pkg::ST_FAULT && !cmd_s[`GDFM_CH_UP])
      |=> !upper_gate_on_o)
    else $error("Turn-off command did not switch the channel off.");

  a_fault_waits: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state_r == gdfm_pkg::ST_FAULT && !(quiet_done && confirm_done))
      |=> (state_r == gdfm_pkg::ST_FAULT))
    else $error("Fault state left before the reset sequence ended.");

endmodule // gate_driver_fault_manager

// *** dv/pwm_ctrl_model.sv ***
// Controller and neighbour driver core on the far side of the fault manager.
// Assumes the bench resolves the shared halt line from every pull-down.
`timescale 1ns/1ns
module pwm_ctrl_model (
  input wire logic sys_clk_i,
  input wire logic halt_n_i,
  input wire logic slow_i,
  input wire logic want_up_i,
  input wire logic want_lo_i,
  input wire logic pull_i,
  output logic upper_cmd_o,
  output logic lower_cmd_o,
  output logic halt_pull_o
);
  int cnt = 0;
  logic up_ok;
  logic lo_ok;
  // ****************************************************************
  // Halt reaction
  // ****************************************************************
  always @(posedge sys_clk_i) begin
    cnt <= halt_n_i ? 0 : cnt + 1;
  end
  // Upper is turned off before lower, as a multilevel leg needs; the slow
  // variant leaves time to see that a locked channel refuses turn-on.
  assign up_ok = halt_n_i || cnt < (slow_i ? 30 : 2);
  assign lo_ok = halt_n_i || cnt < (slow_i ? 50 : 5);
  // Once off, both commands stay low while halted to confirm the fault.
  assign upper_cmd_o = want_up_i && up_ok;
  assign lower_cmd_o = want_lo_i && lo_ok;
  assign halt_pull_o = pull_i;
endmodule // pwm_ctrl_model

// *** dv/test_gate_driver_fault_manager.sv ***
// Self-checking bench of the fault manager against a reference model.
// Assumes the design files are compiled first and a 25 MHz clock.
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  miscompares++; $display("BAD %0t output differs from model", $time); end end
module test_gate_driver_fault_manager;
  localparam int QC = 8;
  localparam int CC = 4;
  logic sys_clk = 0;
  logic srst = 1;
  logic mode = 0;
  logic ext_up = 1;
  logic ext_lo = 1;
  logic want_up = 0;
  logic want_lo = 0;
  logic pull = 0;
  logic slow = 0;
  logic cmd_up, cmd_lo, pull_w, oe, rep_n, halt_n, f, xf;
  wire logic [5:0] d;
  logic [5:0] s1, s2;
  logic [1:0] m_on, m_sl, aff, x;
  logic m_oe;
  int miscompares = 0;
  int total_checks = 0;
  int seed = 73451;
  int st = 0;
  int qc, cc, it, k;
  always #20 sys_clk = ~sys_clk;
  // The open-drain halt line is low when any party pulls it.
  assign halt_n = ~(oe | pull_w);
  gate_driver_fault_manager #(.QUIET_CYC(QC), .CONFIRM_CYC(CC)) DUT (
    .sys_clk_i(sys_clk), .srst_i(srst), .fault_mode_i(mode),
    .primary_fault_in_n_i(halt_n), .upper_cmd_i(cmd_up),
    .lower_cmd_i(cmd_lo), .upper_ext_fault_n_i(ext_up),
    .lower_ext_fault_n_i(ext_lo), .fault_report_n_o(rep_n),
    .fault_report_n_oe_o(oe), .upper_gate_on_o(d[0]),
    .upper_gate_off_o(d[2]), .upper_gate_slow_off_o(d[4]),
    .lower_gate_on_o(d[1]), .lower_gate_off_o(d[3]),
    .lower_gate_slow_off_o(d[5]));
  pwm_ctrl_model partner (
    .sys_clk_i(sys_clk), .halt_n_i(halt_n), .slow_i(slow),
    .want_up_i(want_up), .want_lo_i(want_lo), .pull_i(pull),
    .upper_cmd_o(cmd_up), .lower_cmd_o(cmd_lo), .halt_pull_o(pull_w));
  // ****************************************************************
  // Reference model: two sync stages, then one registered decision
  // ****************************************************************
  always @(posedge sys_clk) begin
    if (srst) begin
      // Commands read as off and fault inputs as released during reset.
      s1 <= 6'h3c;
      s2 <= 6'h3c;
      st = 0;
      aff = 2'b00;
      m_oe <= 1'b0;
      m_on <= 2'b00;
      m_sl <= 2'b00;
    end else begin
      x = ~s2[3:2];
      xf = |x;
      f = xf | ~s2[4];
      if (st == 0 && f || st == 2 && xf) begin
        st = 1;
        qc = 0;
        cc = 0;
        aff = aff | x;
      end else if (st == 1) begin
        aff = aff | x;
        // The timers' done flags are registered, so release follows them
        // by one edge and still needs the secondary faults quiet.
        if (qc > QC && cc > CC && !xf) st = 2;
        qc = xf ? 0 : qc + 1;
        cc = |s2[1:0] ? 0 : cc + 1;
      end else if (st == 2 && s2[4]) begin
        st = 0;
        aff = 2'b00;
      end
      m_oe <= st == 1;
      m_sl <= st != 0 ? aff : 2'b00;
      m_on <= st != 0 ? m_on & s2[1:0] & ~aff & {2{s2[5]}} : s2[1:0];
      s1 <= {mode, halt_n, ext_lo, ext_up, cmd_lo, cmd_up};
      s2 <= s1;
    end
  end
  // Outputs are settled levels by the falling edge and the model keeps
  // the design's pipeline depth, so every cycle is compared.
  always @(negedge sys_clk) begin
    if (!srst) begin
      `CHK(oe, m_oe)
      `CHK(rep_n, 1'b0)
      `CHK(d[1:0], m_on)
      `CHK(d[5:4], m_sl)
      `CHK(d[3:2], ~m_on & ~m_sl)
    end
  end
  task automatic jiggle(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      want_up = 1'($random(seed));
      want_lo = 1'($random(seed));
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************************************************************
  // Scenarios: each fault source in both modes, prompt and slow partner
  // ****************************************************************
  initial begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 0;
    for (it = 0; it < 12; it++) begin
      mode = 1'(it);
      slow = it >= 6;
      jiggle(12);
      k = (it / 2) % 3;
      pull = k == 0;
      ext_up = k != 1;
      ext_lo = k != 2;
      jiggle(6 + int'($unsigned($random(seed)) % 10));
      want_up = 0;
      want_lo = 0;
      ext_up = 1;
      ext_lo = 1;
      // A neighbour still pulling keeps the outputs locked after release.
      repeat (30) @(negedge sys_clk);
      pull = 0;
      for (k = 0; k < 200 && (oe !== 1'b0 || halt_n !== 1'b1); k++)
        @(negedge sys_clk);
      if (k == 200) begin
        $display("BAD %0t fault output release timed out", $time);
        miscompares++;
        it = 12;
      end
    end
    give_verdict();
  end
endmodule // test_gate_driver_fault_manager
